//--- write_cmd_defines.vh
`ifndef WRITE_CMD_DEFINES_VH
`define WRITE_CMD_DEFINES_VH
`define FC_WRITE_COIL 8'h05
`define FC_WRITE_REG 8'h06
`define FC_WRITE_COILS 8'h0f
`define FC_WRITE_REGS 8'h10
`define NUM_COILS 16
`define NUM_REGS 8
`define REG_RESET 16'h0000
`define COIL_ON 16'hff00
`define COIL_OFF 16'h0000
`define HDR_LEN 7
`define ECHO_LEN 12
`define MAX_FRAME 64
`endif

//--- tx_serializer.v
`timescale 1ns/10ps
`include "write_cmd_defines.vh"
module tx_serializer (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // load side
    input wire load,
    input wire [8*`ECHO_LEN-1:0] frame,
    output wire busy,
    // byte stream out
    output reg [7:0] tx_data,
    output wire tx_valid,
    input wire tx_ready,
    output wire tx_last
);
    reg [8*`ECHO_LEN-1:0] shift_r;
    reg [3:0] cnt_r;
    assign busy = (cnt_r != 4'h0);
    assign tx_valid = busy;
    assign tx_last = (cnt_r == 4'h1);
    always @* begin
        tx_data = shift_r[8*`ECHO_LEN-1 -: 8];
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= {(8*`ECHO_LEN){1'b0}};
            cnt_r <= 4'h0;
        end else if (load && !busy) begin
            shift_r <= frame;
            cnt_r <= 4'hc;
        end else if (busy && tx_ready) begin
            shift_r <= {shift_r[8*`ECHO_LEN-9:0], 8'h00};
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

//--- write_cmd_handler.v
`timescale 1ns/10ps
`include "write_cmd_defines.vh"
// Overview of operation
// (RQ1) fc 06 writes one analog output register
// (RQ2) addresses are zero based
// (RQ3) echo whole request after register update; code echoes 12 bytes, length 6, even for a longer 05/06 frame
// (RQ4) fc 0f sets consecutive coils from start
// (RQ5) one bit on, zero bit off
// (RQ6) coil bits packed lsb first
// (RQ7) coil reply: fc, start, quantity only
// (RQ8) fc 10 writes contiguous register block
// (RQ9) two data bytes per register, byte count
// (RQ10) high byte first within each register
// (RQ11) register reply: fc, start, quantity
// (RQ12) transaction id copied into reply
// (RQ13) protocol identifier is zero
// (RQ14) length upper byte is zero
// (RQ15) single coil only ff00 or 0000 acts
// (RQ16) bad code or range: no change, no reply
module write_cmd_handler (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // request byte stream, one frame from mbap byte 0
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_last,
    output wire rx_ready,
    // response byte stream
    output wire [7:0] tx_data,
    output wire tx_valid,
    input wire tx_ready,
    output wire tx_last,
    // outputs
    output reg [`NUM_COILS-1:0] coils,
    output wire [16*`NUM_REGS-1:0] analog_out,
    output wire [15:0] second_analog_output_channel,
    output wire first_digital_output_coil,
    output wire second_digital_output_coil
);
    localparam ST_RX = 2'd0;
    localparam ST_EXEC = 2'd1;
    localparam ST_TX = 2'd2;

    reg [1:0] state_r;
    reg [7:0] buf_r [0:`MAX_FRAME-1];
    reg [6:0] len_r;
    reg ovf_r;
    reg [15:0] regs_r [0:`NUM_REGS-1];
    reg load_r;
    wire busy;
    integer i;
    reg [1:0] state_nxt;
    // multi-write decode results, one bit or word per target
    wire [`NUM_COILS-1:0] coil_hit;
    wire [`NUM_COILS-1:0] coil_val;
    wire [`NUM_REGS-1:0] reg_hit;
    wire [16*`NUM_REGS-1:0] reg_val;

    genvar g;
    generate
        for (g = 0; g < `NUM_REGS; g = g + 1) begin : g_ao
            assign analog_out[16*g +: 16] = regs_r[g];
        end
    endgenerate
    assign second_analog_output_channel = regs_r[1];
    assign first_digital_output_coil = coils[0];
    assign second_digital_output_coil = coils[1];

    // parsed fields
    wire [7:0] fc = buf_r[7];
    wire [15:0] addr = {buf_r[8], buf_r[9]};
    wire [15:0] qty = {buf_r[10], buf_r[11]};
    wire [7:0] bcnt = buf_r[12];
    wire [16:0] end_a = {1'b0, addr} + {1'b0, qty};
    wire hdr_ok = (buf_r[2] == 8'h00) && (buf_r[3] == 8'h00) && (buf_r[4] == 8'h00); // RQ13 RQ14
    wire [6:0] frame_len = 7'd6 + buf_r[5][6:0];
    wire len_ok = !ovf_r && (buf_r[5][7] == 1'b0) && (len_r == frame_len) && (len_r >= 7'd12);
    wire ok_reg = (fc == `FC_WRITE_REG) && (addr < `NUM_REGS); // RQ2
    wire ok_coil = (fc == `FC_WRITE_COIL) && (addr < `NUM_COILS) &&
        (qty == `COIL_ON || qty == `COIL_OFF); // RQ15
    wire ok_coils = (fc == `FC_WRITE_COILS) && (qty != 16'h0000) &&
        (end_a <= `NUM_COILS) && ({8'h00, bcnt} == ((qty + 16'h0007) >> 3)) &&
        (len_r == 7'd13 + bcnt[6:0]); // RQ4
    wire ok_regs = (fc == `FC_WRITE_REGS) && (qty != 16'h0000) &&
        (end_a <= `NUM_REGS) && ({8'h00, bcnt} == {qty[14:0], 1'b0}) &&
        (len_r == 7'd13 + bcnt[6:0]); // RQ9
    wire accept = hdr_ok && len_ok && (ok_reg || ok_coil || ok_coils || ok_regs); // RQ16

    // per-coil and per-register decode of a multi-write frame; the offset
    // from the start address picks the data byte and bit
    generate
        for (g = 0; g < `NUM_COILS; g = g + 1) begin : g_coil
            localparam [15:0] POS = g;
            wire [15:0] rel;
            wire [7:0] src;
            assign rel = POS - addr;
            // at most 16 coils, so the data sits in bytes 13 and 14 only
            assign src = rel[3] ? buf_r[14] : buf_r[13];
            assign coil_hit[g] = ok_coils && (POS >= addr) && ({1'b0, POS} < end_a); // RQ4
            assign coil_val[g] = src[rel[2:0]]; // RQ5 RQ6
        end
        for (g = 0; g < `NUM_REGS; g = g + 1) begin : g_reg
            localparam [15:0] POS = g;
            wire [15:0] rel;
            wire [5:0] hi;
            assign rel = POS - addr;
            assign hi = 6'd13 + {2'b00, rel[2:0], 1'b0};
            assign reg_hit[g] = ok_regs && (POS >= addr) && ({1'b0, POS} < end_a); // RQ8
            assign reg_val[16*g +: 16] = {buf_r[hi], buf_r[hi + 6'd1]}; // RQ9 RQ10
        end
    endgenerate

    // reply: for 05/06 an echo, for 0f/10 header with length 6, unit id and first five pdu bytes
    wire [8*`ECHO_LEN-1:0] reply = {buf_r[0], buf_r[1], 8'h00, 8'h00, 8'h00, 8'h06,
        buf_r[6], fc, buf_r[8], buf_r[9], buf_r[10], buf_r[11]}; // RQ3 RQ7 RQ11 RQ12

    assign rx_ready = (state_r == ST_RX);

    // reply bytes leave one per accepted tx_ready
    tx_serializer u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .load(load_r),
        .frame(reply),
        .busy(busy),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready),
        .tx_last(tx_last)
    );

    // no reset on the frame store: it is only read after a full frame
    always @(posedge clk) begin
        if (state_r == ST_RX && rx_valid && len_r < `MAX_FRAME) begin
            buf_r[len_r[5:0]] <= rx_data;
        end
    end

    // next state kept apart so the clocked block only moves data
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RX: begin
                // rx_last alone ends the frame, even one too long to store
                if (rx_valid && rx_last) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_nxt = accept ? ST_TX : ST_RX; // RQ16
            end
            ST_TX: begin
                // wait for the load pulse to reach the serializer first
                if (!load_r && !busy) begin
                    state_nxt = ST_RX;
                end
            end
            default: begin
                state_nxt = ST_RX;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RX;
            len_r <= 7'd0;
            ovf_r <= 1'b0;
            load_r <= 1'b0;
            coils <= {`NUM_COILS{1'b0}};
            for (i = 0; i < `NUM_REGS; i = i + 1) begin
                regs_r[i] <= `REG_RESET;
            end
        end else begin
            state_r <= state_nxt;
            load_r <= 1'b0;
            case (state_r)
                ST_RX: begin
                    // bytes past the store are neither counted nor stored; ovf_r flags the frame, then it is refused
                    if (rx_valid) begin
                        if (len_r < `MAX_FRAME) begin
                            len_r <= len_r + 7'd1;
                        end else begin
                            ovf_r <= 1'b1;
                        end
                    end
                end
                ST_EXEC: begin
                    if (accept) begin
                        if (ok_reg) begin
                            regs_r[addr[2:0]] <= qty; // RQ1 RQ10
                        end
                        if (ok_coil) begin
                            coils[addr[3:0]] <= (qty == `COIL_ON); // RQ15
                        end
                        for (i = 0; i < `NUM_COILS; i = i + 1) begin
                            if (coil_hit[i]) begin
                                coils[i] <= coil_val[i]; // RQ5 RQ6
                            end
                        end
                        for (i = 0; i < `NUM_REGS; i = i + 1) begin
                            if (reg_hit[i]) begin
                                regs_r[i] <= reg_val[16*i +: 16]; // RQ8 RQ10
                            end
                        end
                        load_r <= 1'b1; // RQ3
                    end
                    len_r <= 7'd0;
                    ovf_r <= 1'b0;
                end
                ST_TX: begin
                    // the serializer drains the reply; nothing to hold here
                    len_r <= 7'd0;
                end
                default: begin
                    len_r <= 7'd0;
                end
            endcase
        end
    end
endmodule

//--- write_cmd_checker.sv
`timescale 1ns/10ps
module write_cmd_checker (
    // watched ports
    input wire clk,
    input wire rst_n,
    input wire rx_valid,
    input wire rx_last,
    input wire rx_ready,
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_ready,
    input wire tx_last,
    input wire [15:0] coils,
    input wire [127:0] analog_out
);
    reg [3:0] cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            cnt_r <= 4'h0;
        else if (tx_valid && tx_ready)
            cnt_r <= tx_last ? 4'h0 : cnt_r + 4'h1;
    end
    sequence s_last;
        rx_valid && rx_ready && rx_last;
    endsequence
    a_end_refuse: assert property (s_last |=> !rx_ready)
        else $error("ready after last");
    a_reply_start: assert property (s_last |-> ##[2:3] (tx_valid || rx_ready))
        else $error("frame stuck");
    a_tx_busy: assert property (tx_valid |-> !rx_ready)
        else $error("ready in reply");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped");
    a_out_still: assert property (rx_ready |=> $stable(coils) && $stable(analog_out))
        else $error("outputs moved");
    a_hdr_zero: assert property (tx_valid && cnt_r inside {4'h2, 4'h3, 4'h4}
        |-> tx_data == 8'h00) else $error("header not zero");
    a_len_six: assert property (tx_valid && cnt_r == 4'h5 |-> tx_data == 8'h06)
        else $error("bad length");
    a_reply_size: assert property (tx_valid && tx_last |-> cnt_r == 4'hb)
        else $error("bad reply size");
endmodule
bind write_cmd_handler write_cmd_checker write_cmd_checker_inst (.clk(clk), .rst_n(rst_n),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last), .coils(coils),
    .analog_out(analog_out));

//--- mb_client.sv
`timescale 1ns/10ps
module mb_client (
    // request
    input wire clk,
    output reg [7:0] rx_data,
    output reg rx_valid,
    output reg rx_last,
    input wire rx_ready,
    // reply
    input wire [7:0] tx_data,
    input wire tx_valid,
    output reg tx_ready,
    output reg [95:0] rsp
);
    integer i;
    initial {rx_data, rx_valid, rx_last, tx_ready, rsp} = 107'h0;
    // sink stalls every other cycle
    always @(negedge clk) tx_ready <= ~tx_ready;
    always @(posedge clk) if (tx_valid && tx_ready) rsp <= {rsp[87:0], tx_data};
    task send(input [135:0] f, input integer n);
        for (i = 0; i < n; i = i + 1) begin
            @(negedge clk);
            while (!rx_ready) @(negedge clk);
            {rx_valid, rx_last, rx_data} = {1'b1, i == n - 1, f[8*(n-1-i)+:8]};
            @(posedge clk);
        end
        @(negedge clk);
        {rx_valid, rx_last, rx_data} = {2'b00, ~rx_data};
    endtask
endmodule

//--- modbus_tcp_write_command_handler_tb.sv
`timescale 1ns/10ps
module modbus_tcp_write_command_handler_tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    wire [7:0] rx_data, tx_data;
    wire rx_valid, rx_last, rx_ready, tx_valid, tx_ready, tx_last;
    wire [15:0] coils;
    wire [127:0] analog_out;
    wire [95:0] rsp;
    wire [15:0] second_analog_output_channel;
    wire first_digital_output_coil, second_digital_output_coil;
    integer fail_count = 0, n_compared = 0, cyc = 0;
    write_cmd_handler write_cmd_handler_inst (.clk(clk), .rst_n(rst_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_last(tx_last), .coils(coils),
        .analog_out(analog_out), .second_analog_output_channel(second_analog_output_channel),
        .first_digital_output_coil(first_digital_output_coil),
        .second_digital_output_coil(second_digital_output_coil));
    mb_client mb_client_inst (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rsp(rsp));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end
    task check(input [127:0] seen, exp, input string what);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task xfer(input [135:0] f, input integer n);
        mb_client_inst.send(f, n);
        repeat (60) if (!rx_ready) @(negedge clk);
    endtask
    task complete_run;
        $display("checks %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_reg;
        xfer(136'h7e81_0000_0006_0106_0001_55ff, 12);
        check(analog_out[31:0], 32'h55ff_0000, "reg0 reg1");
        check(rsp, 96'h7e81_0000_0006_0106_0001_55ff, "echo");
        check(second_analog_output_channel, 16'h55ff, "second channel");
    endtask
    task t_coils;
        xfer(136'h0003_0000_0009_010f_0003_000a_02a5_02, 15);
        check(coils, 16'h1528, "coils");
        check(rsp, 96'h0003_0000_0006_010f_0003_000a, "reply");
        xfer(136'h0004_0000_0008_010f_0000_0004_0101, 14);
        check(coils, 16'h1521, "coils");
        check({first_digital_output_coil, second_digital_output_coil}, 2'b10, "coil pins");
    endtask
    task t_regs;
        xfer(136'h0005_0000_000b_0110_0006_0002_0400_0a01_02, 17);
        check(analog_out[127:96], 32'h0102_000a, "reg6 reg7");
        check(rsp, 96'h0005_0000_0006_0110_0006_0002, "reply");
    endtask
    task t_refused;
        xfer(136'h0006_0000_000b_0110_0007_0002_0411_1122_22, 17);
        xfer(136'h0007_0000_0006_0103_0000_0001, 12);
        xfer(136'h0008_0000_0006_0105_0002_1234, 12);
        xfer(136'h000b_0001_0006_0106_0000_1234, 12);
        xfer(136'h000c_0000_0106_0106_0000_1234, 12);
        check(analog_out[15:0], 16'h0000, "reg0 bad header");
        check(rsp, 96'h0005_0000_0006_0110_0006_0002, "reply");
        check({coils, analog_out[127:96]}, 48'h1521_0102_000a, "outputs");
        xfer(136'h0009_0000_0006_0105_0002_ff00, 12);
        xfer(136'h000a_0000_0006_0105_0000_0000, 12);
        check(coils, 16'h1524, "coils");
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reg;
        t_coils;
        t_regs;
        t_refused;
        complete_run;
    end
endmodule
